/* File: design/counter_pkg.sv */
package counter_pkg;
    localparam int unsigned CLK_FREQ_HZ = 250_000_000;
    localparam int unsigned REF_FREQ_HZ = 10_000_000;
    localparam int unsigned REF_DIV_CYCLES = CLK_FREQ_HZ / REF_FREQ_HZ;
    localparam int REF_DIV_W = 5;
    localparam logic [REF_DIV_W-1:0] REF_DIV_LAST =
        REF_DIV_W'(REF_DIV_CYCLES - 1);
    localparam logic [REF_DIV_W-1:0] REF_DIV_ZERO = 5'h00;
    localparam int COUNT_W = 32;
    localparam logic [COUNT_W-1:0] COUNT_ZERO = 32'h00000000;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 32'h00000001;
    localparam int INTERP_W = 8;
    localparam logic [INTERP_W-1:0] INTERP_ZERO = 8'h00;
    localparam logic [INTERP_W-1:0] INTERP_MAX = 8'hFF;
    localparam int PRE_W = 8;
    localparam logic [PRE_W-1:0] PRE_ZERO = 8'h00;
    localparam logic [PRE_W-1:0] PRE_ONE = 8'h01;
    // divide by 4 watches two bits, divide by 256 watches all eight
    localparam logic [PRE_W-1:0] PRE_LOW_MASK = 8'h03;
    localparam logic [PRE_W-1:0] PRE_HIGH_MASK = 8'hFF;
    localparam int DISP_CHARS = 12;
    localparam int DISP_SEGS = 14;
    localparam int DISP_POS_W = 4;
    localparam logic [DISP_SEGS-1:0] SEG_BLANK = 14'h0000;
    localparam logic [DISP_POS_W-1:0] DISP_LAST_POS =
        DISP_POS_W'(DISP_CHARS - 1);

    typedef enum logic [1:0] {MODE_FREQ_A, MODE_FREQ_B, MODE_PERIOD_A} mode_e;
    typedef enum logic [2:0] {ST_IDLE, ST_ARMED, ST_OPEN, ST_CLOSING,
                              ST_DONE} meas_state_e;
endpackage

/* File: design/prescale_if.sv */
`timescale 1ns/10ps
interface prescale_if;
    logic chanBLevel;
    logic divHigh;
    logic prescaledEdge;
    modport prescaler (input chanBLevel, input divHigh, output prescaledEdge);
    modport counter (output chanBLevel, output divHigh, input prescaledEdge);
endinterface

/* File: design/channel_b_prescaler.sv */
`timescale 1ns/10ps
module channel_b_prescaler (
    input wire logic clk,                 // system clock
    input wire logic resetn,              // sync reset, active low
    prescale_if.prescaler pre             // channel B level in, edge out
);
    logic prevLevel_reg;
    logic [counter_pkg::PRE_W-1:0] divCnt_reg;
    logic outEdge_reg;
    logic riseB;
    logic [counter_pkg::PRE_W-1:0] mask;

    assign riseB = pre.chanBLevel & ~prevLevel_reg;
    assign mask = pre.divHigh ? counter_pkg::PRE_HIGH_MASK
                              : counter_pkg::PRE_LOW_MASK;
    assign pre.prescaledEdge = outEdge_reg;

    always_ff @(posedge clk)
    begin
        if (!resetn)
            prevLevel_reg <= 1'b0;
        else
            prevLevel_reg <= pre.chanBLevel;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            divCnt_reg <= counter_pkg::PRE_ZERO;
            outEdge_reg <= 1'b0;
        end
        else if (riseB)
        begin
            divCnt_reg <= divCnt_reg + counter_pkg::PRE_ONE;
            outEdge_reg <= ((divCnt_reg & mask) == mask);
        end
        else
            outEdge_reg <= 1'b0;
    end
endmodule // channel_b_prescaler

/* File: design/counter_measurement_sequencer.sv */
`timescale 1ns/10ps
module counter_measurement_sequencer (
    input wire logic clk,                          // 250 MHz system clock
    input wire logic resetn,                       // sync reset, active low
    input wire logic modelHigh,                    // strap: 1 = divide by 256
    input wire logic chanA,                        // conditioned channel A
    input wire logic chanB,                        // conditioned channel B
    input wire logic extRefSel,                    // 1 = external timebase
    input wire logic extRefIn,                     // external 10 MHz level
    input wire logic [1:0] modeSel,                // requested mode code
    input wire logic cfgLoad,                      // pulse: take modeSel
    input wire logic [31:0] gateTime,              // gate interval length
    input wire logic armReq,                       // pulse: arm the counter
    input wire logic interpolatorClear,            // clear interpolator
    input wire logic dispWrite,                    // pulse: write one char
    input wire logic [3:0] dispPos,                // character position
    input wire logic [13:0] dispSegs,              // segment pattern
    output logic [1:0] activeMode,                 // mode in force
    output logic armed,                            // waiting for first edge
    output logic gateOpen,                         // counting gate open
    output logic measDone,                         // results ready to read
    output logic [31:0] eventCount,                // gated input events
    output logic [31:0] refCount,                  // gated reference ticks
    output logic [7:0] interpStart,                // open-side fraction
    output logic [7:0] interpStop,                 // close-side fraction
    output logic [167:0] displaySegments           // 12 x 14 segments
);
    prescale_if pre ();

    counter_pkg::meas_state_e state_reg;
    counter_pkg::mode_e mode_reg;
    logic divHigh_reg;
    logic strapTaken_reg;
    logic prevA_reg;
    logic prevExt_reg;
    logic [counter_pkg::REF_DIV_W-1:0] refDiv_reg;
    logic [counter_pkg::COUNT_W-1:0] eventCount_reg;
    logic [counter_pkg::COUNT_W-1:0] refCount_reg;
    logic [counter_pkg::COUNT_W-1:0] gateTime_reg;
    logic interpRun_reg;
    logic interpPhase_reg;
    logic [counter_pkg::INTERP_W-1:0] interpCnt_reg;
    logic [counter_pkg::INTERP_W-1:0] interpStart_reg;
    logic [counter_pkg::INTERP_W-1:0] interpStop_reg;
    logic [counter_pkg::DISP_SEGS-1:0] dispMem_reg [counter_pkg::DISP_CHARS];
    logic riseA;
    logic measEdge;
    logic refTick;
    logic gateEvent;
    logic expired;
    logic counting;

    function automatic logic [counter_pkg::COUNT_W-1:0] inc_count(
        input logic [counter_pkg::COUNT_W-1:0] v);
        inc_count = v + counter_pkg::COUNT_ONE;
    endfunction

    function automatic counter_pkg::mode_e decode_mode(input logic [1:0] c);
        unique case (c)
            2'h1: decode_mode = counter_pkg::MODE_FREQ_B;
            2'h2: decode_mode = counter_pkg::MODE_PERIOD_A;
            default: decode_mode = counter_pkg::MODE_FREQ_A;
        endcase
    endfunction

    channel_b_prescaler u_prescaler (
        .clk(clk),
        .resetn(resetn),
        .pre(pre.prescaler)
    );

    assign pre.chanBLevel = chanB;
    assign pre.divHigh = divHigh_reg;

    // model strap is caught once, on the first edge after reset release
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            strapTaken_reg <= 1'b0;
            divHigh_reg <= 1'b0;
        end
        else if (!strapTaken_reg)
        begin
            strapTaken_reg <= 1'b1;
            divHigh_reg <= modelHigh;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            prevA_reg <= 1'b0;
            prevExt_reg <= 1'b0;
        end
        else
        begin
            prevA_reg <= chanA;
            prevExt_reg <= extRefIn;
        end
    end

    assign riseA = chanA & ~prevA_reg;
    assign measEdge = (mode_reg == counter_pkg::MODE_FREQ_B)
                      ? pre.prescaledEdge : riseA;

    always_ff @(posedge clk)
    begin
        if (!resetn || refDiv_reg == counter_pkg::REF_DIV_LAST)
            refDiv_reg <= counter_pkg::REF_DIV_ZERO;
        else
            refDiv_reg <= refDiv_reg + 5'h01;
    end
    assign refTick = extRefSel ? (extRefIn & ~prevExt_reg)
                               : (refDiv_reg == counter_pkg::REF_DIV_LAST);

    // mode changes only while no measurement is under way
    always_ff @(posedge clk)
    begin
        if (!resetn)
            mode_reg <= counter_pkg::MODE_FREQ_A;
        else if (cfgLoad && (state_reg == counter_pkg::ST_IDLE ||
                             state_reg == counter_pkg::ST_DONE))
            mode_reg <= decode_mode(modeSel);
    end

    assign counting = (state_reg == counter_pkg::ST_OPEN) ||
                      (state_reg == counter_pkg::ST_CLOSING);
    // period mode ends on event count, frequency modes on reference time
    assign expired = (mode_reg == counter_pkg::MODE_PERIOD_A)
                     ? (eventCount_reg >= gateTime_reg)
                     : (refCount_reg >= gateTime_reg);

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            state_reg <= counter_pkg::ST_IDLE;
            gateTime_reg <= counter_pkg::COUNT_ZERO;
        end
        else
        begin
            unique case (state_reg)
                counter_pkg::ST_IDLE, counter_pkg::ST_DONE:
                    if (armReq)
                    begin
                        state_reg <= counter_pkg::ST_ARMED;
                        gateTime_reg <= gateTime;
                    end
                counter_pkg::ST_ARMED:
                    if (measEdge)
                        state_reg <= counter_pkg::ST_OPEN;
                counter_pkg::ST_OPEN:
                    if (expired)
                        state_reg <= counter_pkg::ST_CLOSING;
                counter_pkg::ST_CLOSING:
                    if (measEdge)
                        state_reg <= counter_pkg::ST_DONE;
            endcase
        end
    end

    // counts clear at arm so a stale result never mixes with a new one
    always_ff @(posedge clk)
    begin
        if (!resetn || (armReq && (state_reg == counter_pkg::ST_IDLE ||
                                   state_reg == counter_pkg::ST_DONE)))
        begin
            eventCount_reg <= counter_pkg::COUNT_ZERO;
            refCount_reg <= counter_pkg::COUNT_ZERO;
        end
        else if (counting)
        begin
            if (measEdge)
                eventCount_reg <= inc_count(eventCount_reg);
            if (refTick)
                refCount_reg <= inc_count(refCount_reg);
        end
    end

    assign gateEvent = measEdge && (state_reg == counter_pkg::ST_ARMED ||
                                    state_reg == counter_pkg::ST_CLOSING);

    // fraction from gate edge to next tick
    // a gate edge during a running interpolation restarts it
    always_ff @(posedge clk)
    begin
        if (!resetn || interpolatorClear)
        begin
            interpRun_reg <= 1'b0;
            interpPhase_reg <= 1'b0;
            interpCnt_reg <= counter_pkg::INTERP_ZERO;
            interpStart_reg <= counter_pkg::INTERP_ZERO;
            interpStop_reg <= counter_pkg::INTERP_ZERO;
        end
        else if (gateEvent)
        begin
            interpRun_reg <= 1'b1;
            interpPhase_reg <= (state_reg == counter_pkg::ST_CLOSING);
            interpCnt_reg <= counter_pkg::INTERP_ZERO;
        end
        else if (interpRun_reg && refTick)
        begin
            interpRun_reg <= 1'b0;
            if (interpPhase_reg)
                interpStop_reg <= interpCnt_reg;
            else
                interpStart_reg <= interpCnt_reg;
        end
        else if (interpRun_reg && interpCnt_reg != counter_pkg::INTERP_MAX)
            interpCnt_reg <= interpCnt_reg + 8'h01;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < counter_pkg::DISP_CHARS; i++)
                dispMem_reg[i] <= counter_pkg::SEG_BLANK;
        end
        else if (dispWrite && dispPos <= counter_pkg::DISP_LAST_POS)
            dispMem_reg[dispPos] <= dispSegs;
    end

    always_comb
    begin
        for (int i = 0; i < counter_pkg::DISP_CHARS; i++)
            displaySegments[i*counter_pkg::DISP_SEGS +:
                            counter_pkg::DISP_SEGS] = dispMem_reg[i];
    end

    assign activeMode = mode_reg;
    assign armed = (state_reg == counter_pkg::ST_ARMED);
    assign gateOpen = counting;
    assign measDone = (state_reg == counter_pkg::ST_DONE) && !interpRun_reg;
    assign eventCount = eventCount_reg;
    assign refCount = refCount_reg;
    assign interpStart = interpStart_reg;
    assign interpStop = interpStop_reg;
endmodule // counter_measurement_sequencer

/* File: verification/counter_measurement_sequencer_monitor.sv */
`timescale 1ns/10ps
module counter_measurement_sequencer_monitor (
    input wire logic clk, // clock
    input wire logic resetn, // reset
    input wire logic chanA, // channel A
    input wire logic armReq, // arm pulse
    input wire logic interpolatorClear, // interp clear
    input wire logic [31:0] gateTime, // interval
    input wire logic [1:0] activeMode, // mode
    input wire logic armed, // armed
    input wire logic gateOpen, // gate
    input wire logic measDone, // done
    input wire logic [31:0] eventCount, // events
    input wire logic [31:0] refCount, // ticks
    input wire logic [7:0] interpStart, // open frac
    input wire logic [7:0] interpStop, // close frac
    input wire logic [167:0] displaySegments // display
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    sequence armTaken;
        armReq && !armed && !gateOpen;
    endsequence
    // channel B mode ignores A edges
    sequence edgeOnA;
        armed && $rose(chanA) && activeMode != 2'h1;
    endsequence
    sequence gateOpened;
        gateOpen && !armed;
    endsequence
    arm_answer_a: assert property (armTaken |=> armed)
        else $error("arm request not answered");
    edge_opens_a: assert property (edgeOnA |-> ##[1:2] gateOpened)
        else $error("gate did not open on edge");
    armed_zero_a: assert property (armed |-> !(eventCount | refCount))
        else $error("counts not cleared while armed");
    gate_expiry_a: assert property ($fell(gateOpen) |->
        (activeMode == 2'h2 ? eventCount : refCount) >= gateTime)
        else $error("gate closed before interval");
    done_closed_a: assert property (measDone |-> !gateOpen && !armed)
        else $error("done flag while gate open");
    result_holds_a: assert property (
        measDone && !armReq && !interpolatorClear |=>
        measDone && $stable(eventCount) && $stable(refCount))
        else $error("results changed while done");
    clear_interp_a: assert property (interpolatorClear |=>
        interpStart == 8'h00 && interpStop == 8'h00)
        else $error("interpolator not cleared");
    interp_bound_a: assert property (measDone |->
        interpStart <= 8'h19 && interpStop <= 8'h19)
        else $error("fraction above one tick");
    reset_blank_a: assert property ($rose(resetn) |->
        displaySegments == '0 && !measDone && eventCount == 32'h0)
        else $error("outputs not cleared by reset");
endmodule // counter_measurement_sequencer_monitor

bind counter_measurement_sequencer counter_measurement_sequencer_monitor mon (
    .clk, .resetn, .chanA, .armReq, .interpolatorClear, .gateTime,
    .activeMode, .armed, .gateOpen, .measDone, .eventCount, .refCount,
    .interpStart, .interpStop, .displaySegments);

/* File: verification/controller_model.sv */
`timescale 1ns/10ps
module controller_model (
    input wire logic clk, // system clock
    input wire logic resetn, // sync reset
    input wire logic go, // start one cycle
    input wire logic [1:0] modeReq, // wanted mode
    input wire logic measDone, // counter done
    output logic cfgLoad = 1'b0, // take mode
    output logic armReq = 1'b0, // arm pulse
    output logic [1:0] modeSel = 2'h0, // mode code
    output logic interpolatorClear = 1'b0, // interp clear
    output logic doneSeen = 1'b0 // result read
);
    logic [1:0] stepReg = 2'h0;
    always @(posedge clk)
    begin
        cfgLoad <= 1'b0;
        armReq <= 1'b0;
        interpolatorClear <= 1'b0;
        doneSeen <= 1'b0;
        if (!resetn)
            stepReg <= 2'h0;
        else if (stepReg == 2'h0 && go)
        begin
            modeSel <= modeReq;
            cfgLoad <= 1'b1;
            interpolatorClear <= 1'b1;
            stepReg <= 2'h1;
        end
        else if (stepReg == 2'h1)
        begin
            armReq <= 1'b1;
            stepReg <= 2'h2;
        end
        // done flag of the last run stands until the arm is taken
        else if (stepReg == 2'h2)
            stepReg <= 2'h3;
        else if (stepReg == 2'h3 && measDone)
        begin
            doneSeen <= 1'b1;
            stepReg <= 2'h0;
        end
    end
endmodule // controller_model

/* File: verification/counter_measurement_sequencer_test.sv */
`timescale 1ns/10ps
module counter_measurement_sequencer_test;
    logic clk = 1'b0, resetn = 1'b0, modelHigh = 1'b0, chanA = 1'b0;
    logic chanB = 1'b0, extRefSel = 1'b0, extRefIn = 1'b0, go = 1'b0;
    logic dispWrite = 1'b0, cfgLoad, armReq, interpolatorClear, doneSeen;
    logic armed, gateOpen, measDone;
    logic [1:0] modeReq = 2'h0, modeSel, activeMode;
    logic [3:0] dispPos = 4'h0;
    logic [13:0] dispSegs = 14'h0000;
    logic [31:0] gateTime = 32'h0, eventCount, refCount;
    logic [7:0] interpStart, interpStop;
    logic [167:0] displaySegments;
    int failures = 0, checks_done = 0, cyc = 0, aHalf = 0, bHalf = 0;
    int xHalf = 0;

    controller_model ctl (.clk(clk), .resetn(resetn), .go(go),
        .modeReq(modeReq), .measDone(measDone), .cfgLoad(cfgLoad),
        .armReq(armReq), .modeSel(modeSel),
        .interpolatorClear(interpolatorClear), .doneSeen(doneSeen));
    counter_measurement_sequencer dut (.clk(clk), .resetn(resetn),
        .modelHigh(modelHigh), .chanA(chanA), .chanB(chanB),
        .extRefSel(extRefSel), .extRefIn(extRefIn), .modeSel(modeSel),
        .cfgLoad(cfgLoad), .gateTime(gateTime), .armReq(armReq),
        .interpolatorClear(interpolatorClear), .dispWrite(dispWrite),
        .dispPos(dispPos), .dispSegs(dispSegs), .activeMode(activeMode),
        .armed(armed), .gateOpen(gateOpen), .measDone(measDone),
        .eventCount(eventCount), .refCount(refCount),
        .interpStart(interpStart), .interpStop(interpStop),
        .displaySegments(displaySegments));

    initial
    begin
        forever #2 clk = ~clk;
    end

    task automatic tally_and_finish;
        $display("failures=%0d checks_done=%0d", failures, checks_done);
        if (failures == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // input waveforms by half period in cycles, zero holds the line
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (aHalf != 0 && cyc % aHalf == 0)
            chanA <= ~chanA;
        if (bHalf != 0 && cyc % bHalf == 0)
            chanB <= ~chanB;
        if (xHalf != 0 && cyc % xHalf == 0)
            extRefIn <= ~extRefIn;
        if (cyc == 40000)
        begin
            failures++;
            tally_and_finish();
        end
    end

    task automatic check_rng(input logic [31:0] got, lo, hi);
        checks_done++;
        if ($isunknown(got) || got < lo || got > hi)
        begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic check_seg(input logic [167:0] got, exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic do_reset(input logic high);
        resetn <= 1'b0;
        modelHigh <= high;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
    endtask

    task automatic measure(input logic [1:0] m, input logic [31:0] gt);
        int n;
        n = 0;
        modeReq <= m;
        gateTime <= gt;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        while (doneSeen !== 1'b1 && n < 20000)
        begin
            @(posedge clk);
            n++;
        end
        check_rng({31'h0, doneSeen}, 32'h1, 32'h1);
    endtask

    // one formatted result frame, written once per run
    task automatic s_display;
        logic [167:0] exp;
        exp = '0;
        check_seg(displaySegments, exp);
        dispWrite <= 1'b1;
        for (int i = 0; i < 13; i++)
        begin
            dispPos <= 4'(i);
            dispSegs <= 14'h2A5A ^ 14'(i);
            if (i < 12)
                exp[14*i +: 14] = 14'h2A5A ^ 14'(i);
            @(posedge clk);
        end
        dispWrite <= 1'b0;
        repeat (2) @(posedge clk);
        check_seg(displaySegments, exp);
    endtask

    // rising A edge every 50 cycles, two internal ticks apart
    task automatic s_period;
        aHalf = 25;
        for (int k = 0; k < 2; k++)
        begin
            measure(2'h2, 32'h3);
            check_rng(eventCount, 32'h4, 32'h4);
            check_rng(refCount, 32'h7, 32'h9);
            check_rng({24'h0, interpStart}, 32'h0, 32'h18);
            // gate length is whole ticks, so both fractions match
            check_rng({24'h0, interpStop}, {24'h0, interpStart},
                      {24'h0, interpStart});
            check_rng({30'h0, activeMode}, 32'h2, 32'h2);
        end
    endtask

    // external ticks every 10 cycles; internal would give 62 events
    task automatic s_ext_ref;
        extRefSel <= 1'b1;
        xHalf = 5;
        aHalf = 2;
        measure(2'h3, 32'hA);
        check_rng(refCount, 32'hA, 32'hB);
        check_rng(eventCount, 32'h18, 32'h1B);
        extRefSel <= 1'b0;
        xHalf = 0;
        aHalf = 0;
    endtask

    // B rises every 2 cycles; the close waits for a prescaled edge
    task automatic s_prescale(input logic high);
        int dv;
        int gt;
        int n;
        dv = high ? 256 : 4;
        gt = high ? 512 : 32;
        n = gt * 25 / (2 * dv);
        do_reset(high);
        bHalf = 1;
        measure(2'h1, 32'(gt));
        // first tick may come up to one tick after the open
        check_rng(eventCount, 32'(n - 2), 32'(n + 1));
        check_rng(refCount, 32'(gt), 32'(gt + 2 * dv / 25 + 1));
        bHalf = 0;
    endtask

    initial
    begin
        do_reset(1'b0);
        s_display();
        s_period();
        s_ext_ref();
        s_prescale(1'b0);
        s_prescale(1'b1);
        tally_and_finish();
    end
endmodule // counter_measurement_sequencer_test
